/* File: test/rtc_modulo_counter_tb.sv */
// self-checking bench for the real-time modulo counter: strobe writes, source pulses, readback compares
// assumes the package, the tick interface and the design modules are compiled first
`timescale 1ns/100ps
`default_nettype none

module rtc_modulo_counter_tb;
	import rtc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// bench signals
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic [NUM_SRC-1:0] src = '0;
	logic sc_wr = 1'b0;
	logic [SC_W-1:0] sc_wdata = '0;
	logic mod_wr = 1'b0;
	logic [CNT_W-1:0] mod_wdata = '0;
	logic cnt_wr = 1'b0;
	logic [CNT_W-1:0] cnt_wdata = '0;
	logic [SC_W-1:0] sc_rd;
	logic [CNT_W-1:0] cnt_rd;
	logic [CNT_W-1:0] mod_rd;
	logic flag;
	logic irq;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_cycles = 0;
	// ceiling well above the roughly 12700 cycles the sequence needs
	localparam int CYCLE_LIMIT = 30000;
	// prescale codes with clock select bit 0 low and their divide ratios
	logic [PS_W-1:0] ps_code [5] = '{4'h1, 4'h2, 4'h9, 4'hB, 4'hC};
	int ps_div [5] = '{8, 32, 2, 10, 16};

	////////////////////////////////////////////////////////////////////////////////
	// design under test
	rtc_modulo_counter rtc_modulo_counter_inst (
		.i_clk_sys(clk_sys),
		.i_resetn(resetn),
		.i_low_power_osc_clock(src[SRC_LOW_POWER]),
		.i_external_reference_clock(src[SRC_EXT]),
		.i_internal_reference_clock(src[SRC_INT]),
		.i_status_control_wr(sc_wr),
		.i_status_control_wdata(sc_wdata),
		.i_modulo_value_wr(mod_wr),
		.i_modulo_value_wdata(mod_wdata),
		.i_count_value_wr(cnt_wr),
		.i_count_value_wdata(cnt_wdata),
		.o_status_control_register(sc_rd),
		.o_count_value(cnt_rd),
		.o_modulo_value(mod_rd),
		.o_compare_match_flag(flag),
		.o_match_irq(irq)
	);

	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	always #25 clk_sys = ~clk_sys;

	// a stuck sequence still reaches the closing report
	always @(posedge clk_sys) begin
		n_cycles++;
		if (n_cycles == CYCLE_LIMIT) begin
			n_mismatch++;
			results();
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// tasks
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// count, flag and request in one call
	task automatic state(input logic [7:0] c, input logic f, input logic r);
		check(cnt_rd, c);
		check({7'h00, flag}, {7'h00, f});
		check({7'h00, irq}, {7'h00, r});
	endtask

	// every input change lands 2 ns after a rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask

	// one-cycle strobe: 0 status/control, 1 modulo, 2 count
	task automatic wr(input int which, input logic [7:0] d);
		step(1);
		sc_wr = (which == 0);
		mod_wr = (which == 1);
		cnt_wr = (which == 2);
		sc_wdata = d;
		mod_wdata = d;
		cnt_wdata = d;
		step(1);
		sc_wr = 1'b0;
		mod_wr = 1'b0;
		cnt_wr = 1'b0;
	endtask

	// n rising edges on one source, slow enough for the synchroniser, then settle
	task automatic pulse(input int s, input int n);
		repeat (n) begin
			src[s] = 1'b1;
			step(3);
			src[s] = 1'b0;
			step(3);
		end
		step(3);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		#2;
		resetn = 1'b1;
		step(1);
		check(sc_rd, 8'h00);
		check(mod_rd, 8'h00);
		state(8'h00, 1'b0, 1'b0);
		pulse(SRC_LOW_POWER, 3);
		state(8'h00, 1'b0, 1'b0);
		// divide by one, request enabled, modulo zero: flag on every tick
		wr(0, 8'h18);
		check(sc_rd, 8'h18);
		pulse(SRC_LOW_POWER, 1);
		state(8'h00, 1'b1, 1'b1);
		check(sc_rd, 8'h98);
		wr(0, 8'h18);
		state(8'h00, 1'b1, 1'b1);
		wr(0, 8'h98);
		state(8'h00, 1'b0, 1'b0);
		// tick lands in the clearing cycle: the set must win
		src[SRC_LOW_POWER] = 1'b1;
		step(2);
		wr(0, 8'h98);
		src[SRC_LOW_POWER] = 1'b0;
		step(3);
		state(8'h00, 1'b1, 1'b1);
		wr(0, 8'h98);
		state(8'h00, 1'b0, 1'b0);
		wr(1, 8'h03);
		check(mod_rd, 8'h03);
		pulse(SRC_LOW_POWER, 3);
		state(8'h03, 1'b0, 1'b0);
		pulse(SRC_LOW_POWER, 1);
		state(8'h00, 1'b1, 1'b1);
		// clear the flag and drop the enable, same source and prescale
		wr(0, 8'h88);
		state(8'h00, 1'b0, 1'b0);
		pulse(SRC_LOW_POWER, 4);
		state(8'h00, 1'b1, 1'b0);
		wr(0, 8'h98);
		pulse(SRC_LOW_POWER, 2);
		state(8'h02, 1'b0, 1'b0);
		wr(2, 8'h55);
		check(cnt_rd, 8'h02);
		wr(0, 8'h18);
		check(cnt_rd, 8'h02);
		wr(1, 8'hFF);
		check(mod_rd, 8'hFF);
		check(cnt_rd, 8'h00);
		pulse(SRC_LOW_POWER, 2);
		// internal reference with bit 0 low keeps divide by one
		wr(0, 8'h58);
		check(cnt_rd, 8'h00);
		pulse(SRC_LOW_POWER, 2);
		pulse(SRC_EXT, 2);
		check(cnt_rd, 8'h00);
		pulse(SRC_INT, 2);
		check(cnt_rd, 8'h02);
		// code 11 is still internal, bit 0 high makes code 8 divide by 1000
		wr(0, 8'h78);
		check(cnt_rd, 8'h00);
		pulse(SRC_INT, 999);
		check(cnt_rd, 8'h00);
		pulse(SRC_INT, 1);
		check(cnt_rd, 8'h01);
		wr(0, 8'h38);
		check(cnt_rd, 8'h00);
		pulse(SRC_INT, 2);
		pulse(SRC_LOW_POWER, 2);
		pulse(SRC_EXT, 1000);
		check(cnt_rd, 8'h01);
		// binary and decimal ratios from the low-power source
		for (int i = 0; i < 5; i++) begin
			wr(0, {4'h1, ps_code[i]});
			check(cnt_rd, 8'h00);
			pulse(SRC_LOW_POWER, ps_div[i] - 1);
			check(cnt_rd, 8'h00);
			pulse(SRC_LOW_POWER, 1);
			check(cnt_rd, 8'h01);
		end
		// second reset in mid-run
		resetn = 1'b0;
		step(2);
		resetn = 1'b1;
		step(1);
		check(sc_rd, 8'h00);
		check(mod_rd, 8'h00);
		state(8'h00, 1'b0, 1'b0);
		pulse(SRC_LOW_POWER, 2);
		check(cnt_rd, 8'h00);
		results();
	end

endmodule // rtc_modulo_counter_tb

`default_nettype wire

/* File: verilog/rtc_modulo_counter.sv */
// real-time modulo counter core: select fields, modulo compare, match flag and request
// assumes software writes arrive as one-cycle strobes on the system clock and the
// three source clocks are free-running pins slower than half the system clock
//
// Behaviour
// - 8-bit up-counter against 8-bit modulo, fed by source select and prescaler.
// - reset leaves counter stopped at zero, modulo zero, prescaler off.
// - reset selects the 1 kHz low-power oscillator as source.
// - prescaler off while prescale select is zero; nonzero code starts counting.
// - clock select chooses low-power, external or internal reference clock.
// - writing a different clock select clears prescaler and counter.
// - writing a different prescale select clears prescaler and counter.
// - divide ratio comes from prescale select and clock select bit zero.
// - any modulo value from 0x00 to 0xFF is accepted.
// - counter steps once per prescaler period, wraps to zero on match.
// - match flag sets as counter moves from modulo value to zero.
// - any write to modulo clears prescaler and counter.
// - request raised while match flag and its enable are both set.
// - writing one to the flag clears it and withdraws the request.
// - clock select 00 low-power, 01 external, 1x internal reference.
// - prescale code zero off, others divide by the tabled ratios.
// - modulo zero sets the flag on every prescaler tick.
// - count is read-only; writes to it change nothing.
`timescale 1ns/100ps
`default_nettype none

module rtc_modulo_counter
	import rtc_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// counter source clocks, asynchronous pins
	input wire logic i_low_power_osc_clock,
	input wire logic i_external_reference_clock,
	input wire logic i_internal_reference_clock,
	// software write strobes and data
	input wire logic i_status_control_wr,
	input wire logic [SC_W-1:0] i_status_control_wdata,
	input wire logic i_modulo_value_wr,
	input wire logic [CNT_W-1:0] i_modulo_value_wdata,
	input wire logic i_count_value_wr,
	input wire logic [CNT_W-1:0] i_count_value_wdata,
	// readback
	output logic [SC_W-1:0] o_status_control_register,
	output logic [CNT_W-1:0] o_count_value,
	output logic [CNT_W-1:0] o_modulo_value,
	// flag and request
	output logic o_compare_match_flag,
	output logic o_match_irq
);

	////////////////////////////////////////////////////////////////////////
	// state
	logic [CKS_W-1:0] clock_source_select_q;
	logic [PS_W-1:0] prescale_select_q;
	logic match_interrupt_enable_q;
	logic compare_match_flag_q;
	logic compare_match_flag_d;
	logic [CNT_W-1:0] modulo_value_q;
	logic [CNT_W-1:0] count_value_q;
	logic [CNT_W-1:0] count_value_d;
	logic [NUM_SRC-1:0] src_rise;
	logic [NUM_SRC-1:0] src_pins;

	rtc_tick_if t ();

	////////////////////////////////////////////////////////////////////////
	// source clocks
	assign src_pins[SRC_LOW_POWER] = i_low_power_osc_clock;
	assign src_pins[SRC_EXT] = i_external_reference_clock;
	assign src_pins[SRC_INT] = i_internal_reference_clock;

	// synchronise each source
	// sampling trades edge accuracy of one system cycle for a single clock domain
	for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
		rtc_sync_edge u_sync (
			.i_clk_sys(i_clk_sys),
			.i_resetn(i_resetn),
			.i_async(src_pins[g]),
			.o_rise(src_rise[g])
		);
	end

	// decode source select
	// either code with the upper bit set picks the internal reference
	wire src_is_int = clock_source_select_q[CKS_MSB-CKS_LSB];
	wire src_is_ext = (clock_source_select_q == CKS_EXT);
	wire sel_edge = src_is_int ? src_rise[SRC_INT] : (src_is_ext ? src_rise[SRC_EXT] : src_rise[SRC_LOW_POWER]);

	////////////////////////////////////////////////////////////////////////
	// software write decode
	wire [CKS_W-1:0] cks_new = i_status_control_wdata[CKS_MSB:CKS_LSB];
	wire [PS_W-1:0] ps_new = i_status_control_wdata[PS_MSB:PS_LSB];
	wire ie_new = i_status_control_wdata[IE_BIT];
	wire flag_clear_req = i_status_control_wr && i_status_control_wdata[FLAG_BIT];
	wire cks_change = i_status_control_wr && (cks_new != clock_source_select_q);
	wire ps_change = i_status_control_wr && (ps_new != prescale_select_q);
	// modulo write clears
	// rewriting the same select values does not disturb the count
	wire counters_clr = cks_change || ps_change || i_modulo_value_wr;

	wire [4:0] div_index = {clock_source_select_q[0], prescale_select_q};

	////////////////////////////////////////////////////////////////////////
	// prescaler hookup
	// prescaler runs only on nonzero code
	assign t.en = (prescale_select_q != PS_OFF);
	assign t.clr = counters_clr;
	assign t.div = DIV_TABLE[div_index];
	assign t.src_edge = sel_edge;

	rtc_prescaler u_prescaler (
		.i_clk_sys(i_clk_sys),
		.i_resetn(i_resetn),
		.t(t.pre)
	);

	////////////////////////////////////////////////////////////////////////
	// compare and next count
	// full modulo range compared
	wire count_at_mod = (count_value_q == modulo_value_q);
	wire count_tick = t.tick && !counters_clr;
	wire match_event = count_tick && count_at_mod;

	// step or wrap
	// clearing has priority over a tick landing in the same cycle
	always_comb begin
		count_value_d = count_value_q;
		if (counters_clr) begin
			count_value_d = CNT_ZERO;
		end else if (match_event) begin
			count_value_d = CNT_ZERO;
		end else if (count_tick) begin
			count_value_d = count_value_q + 8'h01;
		end
	end

	// flag on wrap, set beats clear
	// write one clears flag
	// a match in the clearing cycle survives so no event is lost
	always_comb begin
		compare_match_flag_d = compare_match_flag_q;
		if (match_event) begin
			compare_match_flag_d = 1'b1;
		end else if (flag_clear_req) begin
			compare_match_flag_d = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset state
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			clock_source_select_q <= CKS_LOW_POWER;
			prescale_select_q <= PS_OFF;
			match_interrupt_enable_q <= 1'b0;
			modulo_value_q <= MOD_RESET;
		end else begin
			if (i_status_control_wr) begin
				clock_source_select_q <= cks_new;
				prescale_select_q <= ps_new;
				match_interrupt_enable_q <= ie_new;
			end
			if (i_modulo_value_wr) begin
				modulo_value_q <= i_modulo_value_wdata;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			count_value_q <= CNT_ZERO;
			compare_match_flag_q <= 1'b0;
		end else begin
			count_value_q <= count_value_d;
			compare_match_flag_q <= compare_match_flag_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign o_status_control_register = {compare_match_flag_q, clock_source_select_q,
		match_interrupt_enable_q, prescale_select_q};
	assign o_count_value = count_value_q;
	assign o_modulo_value = modulo_value_q;
	assign o_compare_match_flag = compare_match_flag_q;
	assign o_match_irq = compare_match_flag_q && match_interrupt_enable_q;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_resetn);

	sequence s_match_event;
		t.tick && !counters_clr && (count_value_q == modulo_value_q);
	endsequence

	sequence s_flag_clear;
		i_status_control_wr && i_status_control_wdata[FLAG_BIT] && !match_event;
	endsequence

	sequence s_select_change;
		i_status_control_wr && ((cks_new != clock_source_select_q) || (ps_new != prescale_select_q));
	endsequence

	a_reset_state: assert property (@(posedge i_clk_sys) disable iff (1'b0)
		$rose(i_resetn) |-> (count_value_q == CNT_ZERO) && (modulo_value_q == MOD_RESET)
			&& (prescale_select_q == PS_OFF) && !compare_match_flag_q)
		else $error("state not cleared by reset");

	a_default_source: assert property (@(posedge i_clk_sys) disable iff (1'b0)
		$rose(i_resetn) |-> (clock_source_select_q == CKS_LOW_POWER) && !o_match_irq)
		else $error("reset did not select the low-power source");

	a_select_clears: assert property (
		s_select_change |=> (count_value_q == CNT_ZERO) ##1 (count_value_q == CNT_ZERO))
		else $error("counter not cleared by a select change");

	a_modulo_clears: assert property (
		i_modulo_value_wr |=> (count_value_q == CNT_ZERO) && (modulo_value_q == $past(i_modulo_value_wdata)))
		else $error("modulo write did not clear the counter");

	a_count_step: assert property (
		(count_tick && !count_at_mod) |=> (count_value_q == $past(count_value_q) + 8'h01))
		else $error("counter did not step by one on a tick");

	a_match_wrap: assert property (
		s_match_event |=> (count_value_q == CNT_ZERO) && compare_match_flag_q)
		else $error("match did not wrap the counter and set the flag");

	a_count_read_only: assert property (
		(i_count_value_wr && !t.tick && !counters_clr) |=> $stable(count_value_q))
		else $error("count changed on a write to it");

	a_off_holds: assert property (
		(prescale_select_q == PS_OFF) && !i_status_control_wr |=> $stable(count_value_q)
			&& (compare_match_flag_q == $past(compare_match_flag_q) || !compare_match_flag_q))
		else $error("count or flag moved while the prescaler was off");

	a_irq_raise: assert property (
		(match_event && match_interrupt_enable_q && !i_status_control_wr) |=> o_match_irq)
		else $error("request not raised on a match with enable set");

	a_flag_clear: assert property (
		s_flag_clear |=> !compare_match_flag_q && !o_match_irq)
		else $error("writing one did not clear the flag and request");

	a_flag_sticky: assert property (
		compare_match_flag_q && !i_status_control_wr |=> compare_match_flag_q)
		else $error("flag dropped without a clearing write");

	a_clear_no_tick: assert property (
		counters_clr |=> !t.tick)
		else $error("prescaler ticked right after a clear");

	a_count_hold: assert property (
		!t.tick && !counters_clr |=> $stable(count_value_q))
		else $error("counter moved without a tick");

	a_flag_only_match: assert property (
		!compare_match_flag_q && !match_event |=> !compare_match_flag_q)
		else $error("flag set without a match");

	sequence s_zero_mod_tick;
		(modulo_value_q == CNT_ZERO) && count_tick;
	endsequence

	a_zero_modulo: assert property (
		s_zero_mod_tick |=> compare_match_flag_q && (count_value_q == CNT_ZERO))
		else $error("zero modulo tick did not set the flag");

	a_route_low_power: assert property (
		(clock_source_select_q == CKS_LOW_POWER) |-> (t.src_edge == src_rise[SRC_LOW_POWER]))
		else $error("low-power source not routed to the prescaler");

	a_route_external: assert property (
		(clock_source_select_q == CKS_EXT) |-> (t.src_edge == src_rise[SRC_EXT]))
		else $error("external source not routed to the prescaler");

	a_route_internal: assert property (
		clock_source_select_q[CKS_MSB-CKS_LSB] |-> (t.src_edge == src_rise[SRC_INT]))
		else $error("internal source not routed to the prescaler");

	a_prescaler_gate: assert property (
		(prescale_select_q == PS_OFF) |-> !t.tick)
		else $error("prescaler ticked with a zero code");

	a_irq_withdrawn: assert property (
		i_status_control_wr && !ie_new |=> !o_match_irq)
		else $error("request stayed up after the enable was cleared");
endmodule // rtc_modulo_counter

`default_nettype wire

/* File: verilog/rtc_pkg.sv */
// constants for the real-time modulo counter: field layout, reset values, divide table
// assumes nothing of its surroundings; imported whole by every module of the block except the synchroniser
`default_nettype none

package rtc_pkg;

	// status and control byte layout
	localparam int SC_W = 8;
	localparam int FLAG_BIT = 7;
	localparam int CKS_MSB = 6;
	localparam int CKS_LSB = 5;
	localparam int IE_BIT = 4;
	localparam int PS_MSB = 3;
	localparam int PS_LSB = 0;

	// field widths
	localparam int CNT_W = 8;
	localparam int CKS_W = 2;
	localparam int PS_W = 4;
	localparam int DIV_W = 18;

	// clock source codes and source indices
	localparam logic [CKS_W-1:0] CKS_LOW_POWER = 2'h0;
	localparam logic [CKS_W-1:0] CKS_EXT = 2'h1;
	localparam int NUM_SRC = 3;
	localparam int SRC_LOW_POWER = 0;
	localparam int SRC_EXT = 1;
	localparam int SRC_INT = 2;

	// reset and clear values
	localparam logic [PS_W-1:0] PS_OFF = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] MOD_RESET = 8'h00;
	localparam logic [DIV_W-1:0] DIV_ONE = 18'h00001;
	localparam logic [DIV_W-1:0] DIV_ZERO = 18'h00000;

	// divide ratio indexed by {clock select bit 0, prescale select}; entry 0 of each half is unused
	localparam logic [DIV_W-1:0] DIV_TABLE [0:31] = '{
		18'h00001, 18'h00008, 18'h00020, 18'h00040, 18'h00080, 18'h00100, 18'h00200, 18'h00400,
		18'h00001, 18'h00002, 18'h00004, 18'h0000A, 18'h00010, 18'h00064, 18'h001F4, 18'h003E8,
		18'h00001, 18'h00400, 18'h00800, 18'h01000, 18'h02000, 18'h04000, 18'h08000, 18'h10000,
		18'h003E8, 18'h007D0, 18'h01388, 18'h02710, 18'h04E20, 18'h0C350, 18'h186A0, 18'h30D40
	};

endpackage

`default_nettype wire

/* File: verilog/rtc_prescaler.sv */
// prescaler: counts selected source edges and emits one tick per divide period
// assumes clear and enable come from the counter core on the same clock
`timescale 1ns/100ps
`default_nettype none

module rtc_prescaler
	import rtc_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// link to the counter core
	rtc_tick_if.pre t
);
	logic [DIV_W-1:0] pcnt_q;
	logic tick_q;
	logic [DIV_W-1:0] edges_q;
	wire last_edge = (pcnt_q == (t.div - DIV_ONE));

	////////////////////////////////////////////////////////////////////////
	// divide by table ratio
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			pcnt_q <= DIV_ZERO;
			tick_q <= 1'b0;
		end else if (t.clr || !t.en) begin
			pcnt_q <= DIV_ZERO;
			tick_q <= 1'b0;
		end else if (t.src_edge) begin
			pcnt_q <= last_edge ? DIV_ZERO : pcnt_q + DIV_ONE;
			tick_q <= last_edge;
		end else begin
			tick_q <= 1'b0;
		end
	end

	assign t.tick = tick_q;

	////////////////////////////////////////////////////////////////////////
	// helper: source edges seen since the last tick, read only by checks
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			edges_q <= DIV_ZERO;
		end else if (t.clr || !t.en) begin
			edges_q <= DIV_ZERO;
		end else if (tick_q) begin
			edges_q <= t.src_edge ? DIV_ONE : DIV_ZERO;
		end else if (t.src_edge) begin
			edges_q <= edges_q + DIV_ONE;
		end
	end

	a_tick_period: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		tick_q |-> edges_q == t.div)
		else $error("prescaler tick not after the selected number of source edges");

	a_off_no_tick: assert property (@(posedge i_clk_sys) disable iff (!i_resetn)
		!t.en |=> !tick_q)
		else $error("prescaler ticked while switched off");
endmodule // rtc_prescaler

`default_nettype wire

/* File: verilog/rtc_sync_edge.sv */
// two-flop synchroniser with a rising-edge detector for one slow source clock
// assumes the source runs well below half the system clock
`timescale 1ns/100ps
`default_nettype none

module rtc_sync_edge (
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// asynchronous source and its edge
	input wire logic i_async,
	output logic o_rise
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// only sync_q reads meta_q; the edge detector starts at the second stage
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	// one-cycle pulse per source rising edge
	assign o_rise = sync_q & ~prev_q;
endmodule // rtc_sync_edge

`default_nettype wire

/* File: verilog/rtc_tick_if.sv */
// carrier between the counter core and its prescaler
// assumes both ends run on the system clock
`timescale 1ns/100ps
`default_nettype none

interface rtc_tick_if;
	import rtc_pkg::*;

	logic clr;
	logic en;
	logic [DIV_W-1:0] div;
	logic src_edge;
	logic tick;

	modport ctrl (output clr, output en, output div, output src_edge, input tick);
	modport pre (input clr, input en, input div, input src_edge, output tick);
endinterface

`default_nettype wire
